// [color_sensor_result_bank.sv]
// colour sensor output result bank with buffer, flags and link readout
// assumes a host link front end on link_clk issuing start/stop/byte pulses
// and a converter on mclk pulsing meas_done with a full meas_s word
`timescale 1ns/100ps
module color_sensor_result_bank (
   input wire logic mclk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic link_rst,
   input wire result_bank_pkg::link_req_s link_req,
   output logic [7:0] link_rdata,
   output logic [7:0] state_byte,
   input wire logic meas_done,
   input wire result_bank_pkg::meas_s meas_in,
   input wire logic measuring,
   input wire logic idle_sig,
   input wire logic shutdown_sig,
   input wire logic measure_state,
   input wire logic soft_reset,
   input wire logic gated_sync_mode,
   input wire logic conv_timer_enable,
   output logic measuring_flag
);
   import result_bank_pkg::*;

   // =========================================================
   // link domain: index, byte phase, event toggles
   logic [7:0] idx_r;
   logic phase_r;
   logic start_tg_r;
   logic stop_tg_r;
   logic rd_tg_r;
   logic [7:0] rd_idx_r;
   logic [7:0] wr_data_r;
   logic wr_tg_r;
   logic [7:0] link_rdata_r;
   logic [7:0] rbyte;

   // link copies of bank state, sampled through synchronisers
   logic [7:0] flags_l;
   logic meas_l;

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         idx_r <= 8'h00;
         phase_r <= 1'b0;
      end else if (link_req.set_idx) begin
         idx_r <= link_req.data;
         phase_r <= 1'b0;
      end else if (link_req.rd || link_req.wr) begin
         phase_r <= ~phase_r;
         if (phase_r && idx_r < IDX_LAST)
            idx_r <= idx_r + 8'h01;
      end
   end

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         start_tg_r <= 1'b0;
         stop_tg_r <= 1'b0;
         rd_tg_r <= 1'b0;
         wr_tg_r <= 1'b0;
         rd_idx_r <= 8'h00;
         wr_data_r <= STATE_RESET;
      end else begin
         if (link_req.start)
            start_tg_r <= ~start_tg_r;
         if (link_req.stop)
            stop_tg_r <= ~stop_tg_r;
         if (link_req.rd) begin
            rd_tg_r <= ~rd_tg_r;
            rd_idx_r <= idx_r;
         end
         // only the state byte is written
         if (link_req.wr && idx_r == IDX_STATE && !phase_r) begin
            wr_tg_r <= ~wr_tg_r;
            wr_data_r <= link_req.data;
         end
      end
   end

   // =========================================================
   // mclk domain: result registers and buffer
   meas_s buf_r;
   meas_s res_r;
   logic new_r;
   logic lost_r;
   logic busy_r;
   logic [7:0] state_r;
   logic [7:0] flags_r;
   logic [2:0] st_s_r;
   logic [2:0] sp_s_r;
   logic [2:0] rd_s_r;
   logic [2:0] wr_s_r;
   logic [2:0] armed_r;
   logic start_ev;
   logic stop_ev;
   logic rd_ev;
   logic wr_ev;
   logic clr_bank;
   logic flag_read;
   logic res_read;
   logic [15:0] thermal_word;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_s_r <= SYNC_RESET;
         sp_s_r <= SYNC_RESET;
         rd_s_r <= SYNC_RESET;
         wr_s_r <= SYNC_RESET;
         armed_r <= SYNC_RESET;
      end else begin
         st_s_r <= {st_s_r[1:0], start_tg_r};
         sp_s_r <= {sp_s_r[1:0], stop_tg_r};
         rd_s_r <= {rd_s_r[1:0], rd_tg_r};
         wr_s_r <= {wr_s_r[1:0], wr_tg_r};
         armed_r <= {armed_r[1:0], 1'b1};
      end
   end

   // toggles may stand high across a reset: no edge until stages filled
   assign start_ev = armed_r[2] && (st_s_r[2] ^ st_s_r[1]);
   assign stop_ev = armed_r[2] && (sp_s_r[2] ^ sp_s_r[1]);
   assign rd_ev = armed_r[2] && (rd_s_r[2] ^ rd_s_r[1]);
   assign wr_ev = armed_r[2] && (wr_s_r[2] ^ wr_s_r[1]);
   // bank cleared on reset or config return
   assign clr_bank = soft_reset || !measure_state;
   // rd_idx_r is stable long before rd_ev appears
   assign flag_read = rd_ev && rd_idx_r == IDX_STATE && measure_state;
   assign res_read = rd_ev && rd_idx_r != IDX_STATE
      && rd_idx_r <= IDX_LAST && measure_state;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         buf_r <= '0;
      else if (clr_bank)
         buf_r <= '0;
      else if (meas_done) begin
         buf_r <= meas_in;
         if (meas_in.res_ovf) begin
            buf_r.x <= RES_MAX;
            buf_r.y <= RES_MAX;
            buf_r.z <= RES_MAX;
         end
         // counter restarts, flag only in gated timer
         buf_r.conv_ovf <= meas_in.conv_ovf && gated_sync_mode
            && conv_timer_enable;
         // no temperature in gated without timer
         if (gated_sync_mode && !conv_timer_enable)
            buf_r.thermal <= 12'h000;
      end
   end

   // copy on read start, frozen until stop
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         res_r <= '0;
         busy_r <= 1'b0;
      end else if (clr_bank) begin
         res_r <= '0;
         busy_r <= 1'b0;
      end else if (start_ev && !busy_r) begin
         res_r <= buf_r;
         busy_r <= 1'b1;
      end else if (stop_ev) begin
         busy_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         new_r <= 1'b0;
         lost_r <= 1'b0;
      end else if (clr_bank) begin
         new_r <= 1'b0;
         lost_r <= 1'b0;
      end else begin
         // new cleared by any bank read
         if (meas_done)
            new_r <= 1'b1;
         else if (flag_read || res_read)
            new_r <= 1'b0;
         // lost set on overwrite, flag read clears
         if (meas_done && new_r)
            lost_r <= 1'b1;
         else if (flag_read)
            lost_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         state_r <= STATE_RESET;
      else if (soft_reset)
         state_r <= STATE_RESET;
      else if (wr_ev)
         state_r <= wr_data_r;
   end

   // flags byte assembled as a register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         flags_r <= 8'h00;
      else begin
         flags_r[FLAG_CONV_OVF] <= res_r.conv_ovf;
         flags_r[FLAG_RES_OVF] <= res_r.res_ovf;
         flags_r[FLAG_ADC_OVF] <= res_r.adc_ovf;
         flags_r[FLAG_LOST] <= lost_r;
         flags_r[FLAG_NEW] <= new_r;
         flags_r[FLAG_MEAS] <= measuring;
         flags_r[FLAG_IDLE] <= idle_sig;
         flags_r[FLAG_SHUT] <= shutdown_sig;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         measuring_flag <= 1'b0;
      else
         measuring_flag <= measuring;
   end

   assign state_byte = state_r;

   // =========================================================
   // link readout; bank words are stable while a read is open
   logic [7:0] fl_s1_r;
   logic [7:0] fl_s2_r;
   logic [2:0] ms_s_r;
   logic [7:0] sb_s1_r;
   logic [7:0] sb_s2_r;

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         fl_s1_r <= 8'h00;
         fl_s2_r <= 8'h00;
         sb_s1_r <= STATE_RESET;
         sb_s2_r <= STATE_RESET;
         ms_s_r <= SYNC_RESET;
      end else begin
         fl_s1_r <= flags_r;
         fl_s2_r <= fl_s1_r;
         sb_s1_r <= state_r;
         sb_s2_r <= sb_s1_r;
         ms_s_r <= {ms_s_r[1:0], measure_state};
      end
   end

   assign flags_l = fl_s2_r;
   assign meas_l = ms_s_r[2] & ms_s_r[1];
   assign thermal_word = {THERMAL_PAD, res_r.thermal};

   function automatic logic [7:0] pick(input logic [15:0] w,
                                       input logic hi);
      pick = hi ? w[15:8] : w[7:0];
   endfunction : pick

   always_comb begin
      rbyte = 8'h00;
      case (idx_r)
         IDX_STATE: rbyte = phase_r ? flags_l : sb_s2_r;
         IDX_THERMAL: rbyte = pick(thermal_word, phase_r);
         IDX_X: rbyte = pick(res_r.x, phase_r);
         IDX_Y: rbyte = pick(res_r.y, phase_r);
         IDX_Z: rbyte = pick(res_r.z, phase_r);
         // 24-bit time split over two words
         IDX_CONV_LOW: rbyte = pick(res_r.conv_time[15:0], phase_r);
         IDX_CONV_HIGH: rbyte = phase_r ? PAD_BYTE
            : res_r.conv_time[23:16];
         default: rbyte = 8'h00;
      endcase
   end

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst)
         link_rdata_r <= 8'h00;
      else if (!meas_l && idx_r != IDX_STATE)
         link_rdata_r <= 8'h00;
      else if (!meas_l)
         link_rdata_r <= phase_r ? 8'h00 : sb_s2_r;
      else
         link_rdata_r <= rbyte;
   end

   assign link_rdata = link_rdata_r;

   // =========================================================
   // checks
   // lost after overwrite
   a_lost_set: assert property (@(posedge mclk) disable iff (rst)
      meas_done && new_r && !clr_bank |=> lost_r)
      else $error("lost flag not set on overwrite");
   a_lost_keep: assert property (@(posedge mclk) disable iff (rst)
      lost_r && !flag_read && !clr_bank |=> lost_r)
      else $error("lost flag cleared without flag read");
   a_new_wins: assert property (@(posedge mclk) disable iff (rst)
      meas_done && !clr_bank |=> new_r)
      else $error("new flag lost on same-cycle clear");
   a_new_clear: assert property (@(posedge mclk) disable iff (rst)
      (flag_read || res_read) && !meas_done |=> !new_r)
      else $error("new flag not cleared by read");
   a_res_frozen: assert property (@(posedge mclk) disable iff (rst)
      busy_r && !clr_bank |=> $stable(res_r))
      else $error("results changed during read");
   a_res_copy: assert property (@(posedge mclk) disable iff (rst)
      start_ev && !busy_r && !clr_bank |=> res_r == $past(buf_r))
      else $error("buffer not copied on read start");
   a_bank_clear: assert property (@(posedge mclk) disable iff (rst)
      clr_bank |=> res_r == '0 && !new_r && !lost_r)
      else $error("bank not cleared");
   a_meas_flag: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> flags_r[FLAG_MEAS] == $past(measuring))
      else $error("measuring flag wrong");
   a_saturate: assert property (@(posedge mclk) disable iff (rst)
      meas_done && meas_in.res_ovf && !clr_bank |=> buf_r.x == RES_MAX)
      else $error("channel not saturated");

endmodule : color_sensor_result_bank

// [host_link_model.sv]
// host side of the result bank link: start, index, byte reads, stop
// assumes link_rdata settles one link_clk after index or byte phase moves
`timescale 1ns/100ps
module host_link_model
   import result_bank_pkg::*;
(
   input wire logic link_clk,
   input wire logic [7:0] link_rdata,
   output result_bank_pkg::link_req_s link_req
);
   logic [7:0] rx [0:15];

   initial link_req = '0;

   // =========================================================
   // one request pulse, then spacing for the mclk crossing
   task send(input link_req_s r);
      @(posedge link_clk);
      #1 link_req = r;
      @(posedge link_clk);
      // data no longer qualified, so it moves off the last value
      #1 link_req = {5'h00, ~r.data};
      repeat (7) @(posedge link_clk);
   endtask : send

   task open(input logic [7:0] idx);
      send({5'b10000, 8'h00});
      send({5'b00001, idx});
   endtask : open

   task get(input int n);
      for (int i = 0; i < n; i++) begin
         #1 rx[i] = link_rdata;
         send({5'b00100, 8'h00});
      end
   endtask : get

   task close();
      send({5'b01000, 8'h00});
   endtask : close

   task write(input logic [7:0] idx, input logic [7:0] d);
      open(idx);
      send({5'b00010, d});
      close();
   endtask : write
endmodule : host_link_model

// [result_bank_pkg.sv]
// package for the colour sensor result bank: offsets, flag bits, structs
// assumes a byte-wide host link front end in the link clock domain
package result_bank_pkg;

   // =========================================================
   // register indexes
   localparam logic [7:0] IDX_STATE = 8'h00;
   localparam logic [7:0] IDX_THERMAL = 8'h01;
   localparam logic [7:0] IDX_X = 8'h02;
   localparam logic [7:0] IDX_Y = 8'h03;
   localparam logic [7:0] IDX_Z = 8'h04;
   localparam logic [7:0] IDX_CONV_LOW = 8'h05;
   localparam logic [7:0] IDX_CONV_HIGH = 8'h06;
   localparam logic [7:0] IDX_LAST = 8'h06;

   // =========================================================
   // flag bit positions
   localparam int FLAG_CONV_OVF = 7;
   localparam int FLAG_RES_OVF = 6;
   localparam int FLAG_ADC_OVF = 5;
   localparam int FLAG_LOST = 4;
   localparam int FLAG_NEW = 3;
   localparam int FLAG_MEAS = 2;
   localparam int FLAG_IDLE = 1;
   localparam int FLAG_SHUT = 0;

   // =========================================================
   // reset values and fixed values
   localparam logic [7:0] STATE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [15:0] RES_MAX = 16'hffff;
   localparam logic [3:0] THERMAL_PAD = 4'h0;
   localparam logic [2:0] SYNC_RESET = 3'h0;

   // one finished measurement as delivered by the converter
   typedef struct packed {
      logic [11:0] thermal;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
      logic [23:0] conv_time;
      logic conv_ovf;
      logic res_ovf;
      logic adc_ovf;
   } meas_s;

   // link side byte request
   typedef struct packed {
      logic start;
      logic stop;
      logic rd;
      logic wr;
      logic set_idx;
      logic [7:0] data;
   } link_req_s;

endpackage : result_bank_pkg

// [test_color_sensor_result_bank.sv]
// testbench of the result bank: host reads over the link, converter pulses
// assumes the host_link_model partner and the design package
`timescale 1ns/100ps
module test_color_sensor_result_bank;
   import result_bank_pkg::*;
   logic mclk, rst, link_clk, link_rst, meas_done, measuring, idle_sig;
   logic shutdown_sig, measure_state, soft_reset, measuring_flag;
   logic gated, tmr_en;
   link_req_s link_req;
   logic [7:0] link_rdata, state_byte;
   meas_s meas_in, m1, m2, m3;
   int err_total, total_checks, cycles;
   logic [15:0] w [0:5];

   color_sensor_result_bank dut (.mclk(mclk), .rst(rst),
      .link_clk(link_clk), .link_rst(link_rst), .link_req(link_req),
      .link_rdata(link_rdata), .state_byte(state_byte),
      .meas_done(meas_done), .meas_in(meas_in), .measuring(measuring),
      .idle_sig(idle_sig), .shutdown_sig(shutdown_sig),
      .measure_state(measure_state), .soft_reset(soft_reset),
      .gated_sync_mode(gated), .conv_timer_enable(tmr_en),
      .measuring_flag(measuring_flag));

   host_link_model host (.link_clk(link_clk), .link_rdata(link_rdata),
      .link_req(link_req));

   // =========================================================
   // clocks and timeout
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         results();
      end
   end

   // =========================================================
   // shared tasks
   task results();
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task check(input string nm, input logic [15:0] seen,
              input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task meas(input meas_s m);
      @(posedge mclk);
      #1 meas_in = m;
      meas_done = 1'b1;
      @(posedge mclk);
      #1 meas_done = 1'b0;
      repeat (6) @(posedge mclk);
   endtask : meas

   // whole bank from index 0: state, flags, then six words
   task dump(input meas_s m, input logic [7:0] st, input logic [1:0] ln);
      logic [15:0] ch;
      logic [7:0] f;
      ch = m.res_ovf ? 16'hffff : 16'h0000;
      f = {m.conv_ovf & gated & tmr_en, m.res_ovf, m.adc_ovf, ln, measuring,
         idle_sig, shutdown_sig};
      w[0] = (gated && !tmr_en) ? 16'h0000 : {4'h0, m.thermal};
      w[1] = m.x | ch;
      w[2] = m.y | ch;
      w[3] = m.z | ch;
      w[4] = m.conv_time[15:0];
      w[5] = {8'h00, m.conv_time[23:16]};
      host.open(IDX_STATE);
      host.get(14);
      host.close();
      check("state", {8'h00, host.rx[0]}, {8'h00, st});
      check("flags", {8'h00, host.rx[1]}, {8'h00, f});
      for (int i = 0; i < 6; i++) begin
         ch = {host.rx[2*i+3], host.rx[2*i+2]};
         check("word", ch, w[i]);
      end
   endtask : dump

   task read_x(input logic [15:0] exp);
      host.open(IDX_X);
      host.get(2);
      host.close();
      check("x", {host.rx[1], host.rx[0]}, exp);
   endtask : read_x

   // =========================================================
   // main sequence
   initial begin
      rst = 1'b1;
      link_rst = 1'b1;
      meas_done = 1'b0;
      meas_in = '0;
      measuring = 1'b0;
      idle_sig = 1'b1;
      shutdown_sig = 1'b0;
      measure_state = 1'b1;
      soft_reset = 1'b0;
      gated = 1'b0;
      tmr_en = 1'b0;
      err_total = 0;
      total_checks = 0;
      cycles = 0;
      m1 = {12'habc, 16'h1234, 16'h5678, 16'h9abc, 24'h13579b, 3'b101};
      m2 = {12'h123, 16'h1111, 16'h2222, 16'h3333, 24'h000456, 3'b000};
      m3 = {12'h456, 16'h4444, 16'h5555, 16'h6666, 24'hfedcba, 3'b010};
      repeat (8) @(posedge mclk);
      #1 rst = 1'b0;
      link_rst = 1'b0;
      repeat (8) @(posedge mclk);
      dump('0, 8'h00, 2'b00);
      host.write(IDX_STATE, 8'h5a);
      check("state_byte", {8'h00, state_byte}, 16'h005a);
      meas(m1);
      dump(m1, 8'h5a, 2'b01);
      dump(m1, 8'h5a, 2'b00);
      meas(m2);
      meas(m2);
      read_x(m2.x);
      dump(m2, 8'h5a, 2'b10);
      dump(m2, 8'h5a, 2'b00);
      meas(m3);
      dump(m3, 8'h5a, 2'b01);
      host.open(IDX_X);
      meas(m2);
      host.get(2);
      host.close();
      check("held x", {host.rx[1], host.rx[0]}, 16'hffff);
      read_x(m2.x);
      @(posedge mclk);
      #1 measuring = 1'b1;
      idle_sig = 1'b0;
      shutdown_sig = 1'b1;
      repeat (2) @(posedge mclk);
      #1 check("measuring_flag", {15'h0000, measuring_flag}, 16'h0001);
      dump(m2, 8'h5a, 2'b00);
      @(posedge mclk);
      #1 gated = 1'b1;
      meas(m1);
      dump(m1, 8'h5a, 2'b01);
      @(posedge mclk);
      #1 tmr_en = 1'b1;
      meas(m1);
      dump(m1, 8'h5a, 2'b01);
      @(posedge mclk);
      #1 measure_state = 1'b0;
      read_x(16'h0000);
      @(posedge mclk);
      #1 measure_state = 1'b1;
      host.write(IDX_X, 8'h77);
      check("state_byte", {8'h00, state_byte}, 16'h005a);
      read_x(16'h0000);
      @(posedge mclk);
      #1 soft_reset = 1'b1;
      @(posedge mclk);
      #1 soft_reset = 1'b0;
      repeat (2) @(posedge mclk);
      check("state_byte", {8'h00, state_byte}, 16'h0000);
      meas(m1);
      @(posedge mclk);
      #1 rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (8) @(posedge mclk);
      dump('0, 8'h00, 2'b00);
      results();
   end
endmodule : test_color_sensor_result_bank
